// >>> hdl/scs_clock_switch.sv
// System clock switch control: CPU clock source and divider selection,
// oscillator stop and restart, standby modes and peripheral clock gating.
// Assumes oscillator outputs arrive as pins; all clocks leave as tick pulses.
//
// Added by the designer: the placing of the registers and the address-and-strobe port.
`timescale 1ns/100ps

module scs_clock_switch
  import scs_pkg::*;
#(
  parameter int STAB_PERIODS = STAB_OSC_PERIODS
) (
  input wire logic core_clk,
  input wire logic resetn,
  input wire logic [ADDR_W-1:0] reg_addr,
  input wire logic [DATA_W-1:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [DATA_W-1:0] reg_rdata,
  input wire logic main_osc_pin,
  input wire logic sub_osc_pin,
  input wire logic stop_req,
  input wire logic halt_req,
  input wire logic wake_req,
  output logic main_osc_en,
  output logic sub_osc_feedback_off,
  output logic cpu_clock_source_status,
  output logic cpu_running,
  output logic cpu_clk_tick,
  output logic instr_tick,
  output logic periph_main_tick,
  output logic periph_sub_tick,
  output logic wdt_count_en
);

  // ---------------------------------------------------------------
  // Oscillator edges
  // ---------------------------------------------------------------
  logic fx_rise, fxt_rise;

  scs_edge_sync u_fx_sync (
    .core_clk(core_clk),
    .resetn(resetn),
    .pin(main_osc_pin),
    .rise(fx_rise)
  );

  scs_edge_sync u_fxt_sync (
    .core_clk(core_clk),
    .resetn(resetn),
    .pin(sub_osc_pin),
    .rise(fxt_rise)
  );

  // ---------------------------------------------------------------
  // Registers and state
  // ---------------------------------------------------------------
  scs_pcc_s pcc_q, pcc_d;
  logic mcs_q, mcs_d;
  logic [DATA_W-1:0] rdata_q, rdata_d;
  scs_state_e state_q, state_d;
  logic [17:0] stab_q, stab_d;
  logic osc_en_q, osc_en_d;
  logic active_sub_q, active_sub_d;
  logic [2:0] active_div_q, active_div_d;
  logic pending_q, pending_d;
  logic [WAIT_W-1:0] wait_q, wait_d;
  logic [1:0] stretch_q, stretch_d;
  logic fxx_ph_q, fxx_ph_d;
  logic [3:0] main_cnt_q, main_cnt_d;
  logic sub_ph_q, sub_ph_d;
  logic instr_ph_q, instr_ph_d;

  logic wr_pcc, wr_oscillator_mode_select, fx_live, fxx_tick, main_cpu_tick, sub_cpu_tick;
  logic cpu_tick_raw, run_tick, apply_switch;
  scs_pcc_s wr_val;

  assign wr_pcc = reg_wr && (reg_addr == PROC_CLOCK_CTRL_ADDR);
  assign wr_oscillator_mode_select = reg_wr && (reg_addr == OSC_MODE_ADDR);
  assign wr_val = scs_pcc_s'(reg_wdata);

  // ---------------------------------------------------------------
  // Clock derivation
  // ---------------------------------------------------------------
  always_comb begin
    fx_live = fx_rise && osc_en_q;
    // Edges swallowed after a mode write, so the main clock stretches
    fxx_tick = fx_live && (stretch_q == 2'h0) && (mcs_q || fxx_ph_q);
    main_cpu_tick = fxx_tick &&
                    ((main_cnt_q & scs_div_mask(active_div_q))
                     == scs_div_mask(active_div_q));
    sub_cpu_tick = fxt_rise && sub_ph_q;
    // Divider field plays no part on the sub path
    cpu_tick_raw = active_sub_q ? sub_cpu_tick : main_cpu_tick;
    run_tick = cpu_tick_raw && (state_q == ST_RUN);
    apply_switch = pending_q && run_tick && instr_ph_q && (wait_q <= WAIT_FROM_SUB);
  end

  assign cpu_clk_tick = run_tick;
  assign instr_tick = run_tick && instr_ph_q;
  assign periph_main_tick = fxx_tick;
  assign periph_sub_tick = fxt_rise;
  assign wdt_count_en = !active_sub_q && (state_q != ST_STOP);
  assign cpu_running = (state_q == ST_RUN);
  assign main_osc_en = osc_en_q;
  assign sub_osc_feedback_off = pcc_q.sub_osc_feedback_off;
  assign cpu_clock_source_status = active_sub_q;
  assign reg_rdata = rdata_q;

  always_comb begin
    stretch_d = stretch_q;
    if (wr_oscillator_mode_select) begin
      stretch_d = STRETCH_FX_PERIODS;
    end else if (fx_live && (stretch_q != 2'h0)) begin
      stretch_d = stretch_q - 2'h1;
    end
    fxx_ph_d = fxx_ph_q;
    if (fx_live && (stretch_q == 2'h0)) begin
      fxx_ph_d = !fxx_ph_q;
    end
    main_cnt_d = main_cnt_q;
    sub_ph_d = sub_ph_q;
    instr_ph_d = instr_ph_q;
    if (fxx_tick) begin
      main_cnt_d = main_cnt_q + 4'h1;
    end
    if (fxt_rise) begin
      sub_ph_d = !sub_ph_q;
    end
    if (run_tick) begin
      instr_ph_d = !instr_ph_q;
    end
    // Main divider count and instruction phase restart at the switch point; the sub phase runs on
    if (apply_switch) begin
      main_cnt_d = 4'h0;
      instr_ph_d = 1'b0;
    end
  end

  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      stretch_q <= 2'h0;
      fxx_ph_q <= 1'b0;
      main_cnt_q <= 4'h0;
      sub_ph_q <= 1'b0;
      instr_ph_q <= 1'b0;
    end else begin
      stretch_q <= stretch_d;
      fxx_ph_q <= fxx_ph_d;
      main_cnt_q <= main_cnt_d;
      sub_ph_q <= sub_ph_d;
      instr_ph_q <= instr_ph_d;
    end
  end

  // ---------------------------------------------------------------
  // Register file
  // ---------------------------------------------------------------
  always_comb begin
    pcc_d = pcc_q;
    mcs_d = mcs_q;
    if (wr_pcc) begin
      pcc_d = wr_val;
      pcc_d.zero = 1'b0;
      pcc_d.cpu_clock_source_status = 1'b0;
    end
    if (wr_oscillator_mode_select) begin
      mcs_d = reg_wdata[MAIN_UNDIVIDED_BIT];
    end
    rdata_d = READ_UNMAPPED;
    if (reg_rd && (reg_addr == PROC_CLOCK_CTRL_ADDR)) begin
      rdata_d = pcc_q;
      rdata_d[SOURCE_STATUS_BIT] = active_sub_q;
    end else if (reg_rd && (reg_addr == OSC_MODE_ADDR)) begin
      rdata_d = OSC_MODE_RESET;
      rdata_d[MAIN_UNDIVIDED_BIT] = mcs_q;
    end
  end

  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      pcc_q <= scs_pcc_s'(PROC_CLOCK_CTRL_RESET);
      mcs_q <= OSC_MODE_RESET[MAIN_UNDIVIDED_BIT];
      rdata_q <= READ_UNMAPPED;
    end else begin
      pcc_q <= pcc_d;
      mcs_q <= mcs_d;
      rdata_q <= rdata_d;
    end
  end

  // ---------------------------------------------------------------
  // Delayed switchover
  // ---------------------------------------------------------------
  always_comb begin
    active_sub_d = active_sub_q;
    active_div_d = active_div_q;
    pending_d = pending_q;
    wait_d = wait_q;
    if (wr_pcc) begin
      // Latest write restarts the wait, counted on the clock still in use
      pending_d = (wr_val.clock_select != active_sub_q) ||
                  (wr_val.divider != active_div_q);
      wait_d = scs_switch_wait(active_sub_q, wr_val.clock_select,
                               mcs_q, active_div_q);
    end else if (apply_switch) begin
      active_sub_d = pcc_q.clock_select;
      active_div_d = pcc_q.divider;
      pending_d = 1'b0;
    end else if (pending_q && run_tick && instr_ph_q) begin
      wait_d = wait_q - WAIT_FROM_SUB;
    end
  end

  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      active_sub_q <= 1'b0;
      active_div_q <= DIV_SLOWEST;
      pending_q <= 1'b0;
      wait_q <= WAIT_FROM_SUB;
    end else begin
      active_sub_q <= active_sub_d;
      active_div_q <= active_div_d;
      pending_q <= pending_d;
      wait_q <= wait_d;
    end
  end

  // ---------------------------------------------------------------
  // Oscillator and standby control
  // ---------------------------------------------------------------
  always_comb begin
    state_d = state_q;
    stab_d = stab_q;
    case (state_q)
      ST_STAB: begin
        if (fx_live) begin
          stab_d = stab_q + 18'h1;
        end
        if (fx_live && (stab_q == 18'(STAB_PERIODS - 1))) begin
          state_d = ST_RUN;
          stab_d = 18'h0;
        end
      end
      ST_RUN: begin
        // STOP only on the main clock; the sub path has no stop at all
        if (stop_req && !active_sub_q) begin
          state_d = ST_STOP;
        end else if (halt_req) begin
          state_d = ST_HALT;
        end
      end
      ST_HALT: begin
        if (wake_req) begin
          state_d = ST_RUN;
        end
      end
      ST_STOP: begin
        if (wake_req) begin
          state_d = ST_STAB;
          stab_d = 18'h0;
        end
      end
      default: begin
        state_d = ST_STAB;
        stab_d = 18'h0;
      end
    endcase
    // Stop bit waits until the CPU has really moved to the sub clock
    osc_en_d = (state_d != ST_STOP) && !(pcc_q.main_osc_stop && active_sub_q);
  end

  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      state_q <= ST_STAB;
      stab_q <= 18'h0;
      osc_en_q <= 1'b0;
    end else begin
      state_q <= state_d;
      stab_q <= stab_d;
      osc_en_q <= osc_en_d;
    end
  end

endmodule

// >>> hdl/scs_edge_sync.sv
// Three-stage synchroniser with a filtered rising-edge pulse.
// Assumes the pin toggles well below half the core clock rate.
`timescale 1ns/100ps
module scs_edge_sync (
  input wire logic core_clk,
  input wire logic resetn,
  input wire logic pin,
  output logic rise
);

  logic s1_q, s2_q, s3_q, lvl_q;
  logic lvl_d;

  // A level counts only once stages two and three agree
  always_comb begin
    lvl_d = (s2_q == s3_q) ? s3_q : lvl_q;
    rise = (s2_q == s3_q) && s3_q && !lvl_q;
  end

  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      s1_q <= 1'b0;
      s2_q <= 1'b0;
      s3_q <= 1'b0;
      lvl_q <= 1'b0;
    end else begin
      s1_q <= pin;
      s2_q <= s1_q;
      s3_q <= s2_q;
      lvl_q <= lvl_d;
    end
  end

endmodule

// >>> hdl/scs_pkg.sv
// Shared constants, types and helper functions for the system clock switch.
// Assumes a single 50 MHz core clock and synchronous oscillator edge pulses.
package scs_pkg;

  // ---------------------------------------------------------------
  // Register port
  // ---------------------------------------------------------------
  localparam int ADDR_W = 8;
  localparam int DATA_W = 8;
  localparam logic [ADDR_W-1:0] PROC_CLOCK_CTRL_ADDR = 8'hFB;
  localparam logic [ADDR_W-1:0] OSC_MODE_ADDR = 8'hF9;
  localparam logic [DATA_W-1:0] PROC_CLOCK_CTRL_RESET = 8'h04;
  localparam logic [DATA_W-1:0] OSC_MODE_RESET = 8'h00;
  localparam logic [DATA_W-1:0] READ_UNMAPPED = 8'h00;

  // ---------------------------------------------------------------
  // Field layout
  // ---------------------------------------------------------------
  localparam int MAIN_OSC_STOP_BIT = 7;
  localparam int FEEDBACK_OFF_BIT = 6;
  localparam int SOURCE_STATUS_BIT = 5;
  localparam int CLOCK_SELECT_BIT = 4;
  localparam int DIV_MSB = 2;
  localparam int DIV_LSB = 0;
  localparam int MAIN_UNDIVIDED_BIT = 0;
  localparam logic [2:0] DIV_SLOWEST = 3'h4;

  // ---------------------------------------------------------------
  // Timing
  // ---------------------------------------------------------------
  localparam int STAB_OSC_PERIODS = 131072;
  localparam logic [1:0] STRETCH_FX_PERIODS = 2'h2;
  localparam int WAIT_W = 7;
  localparam logic [WAIT_W-1:0] WAIT_M2M_BASE = 7'h10;
  localparam logic [WAIT_W-1:0] WAIT_FROM_SUB = 7'h01;
  localparam logic [WAIT_W-1:0] WAIT_M2S_E0 = 7'h4D;
  localparam logic [WAIT_W-1:0] WAIT_M2S_E1 = 7'h27;
  localparam logic [WAIT_W-1:0] WAIT_M2S_E2 = 7'h14;
  localparam logic [WAIT_W-1:0] WAIT_M2S_E3 = 7'h0A;
  localparam logic [WAIT_W-1:0] WAIT_M2S_E4 = 7'h05;
  localparam logic [WAIT_W-1:0] WAIT_M2S_E5 = 7'h03;

  // ---------------------------------------------------------------
  // Types
  // ---------------------------------------------------------------
  typedef struct packed {
    logic main_osc_stop;
    logic sub_osc_feedback_off;
    logic cpu_clock_source_status;
    logic clock_select;
    logic zero;
    logic [2:0] divider;
  } scs_pcc_s;

  typedef enum logic [3:0] {
    ST_STAB = 4'h1,
    ST_RUN = 4'h2,
    ST_HALT = 4'h4,
    ST_STOP = 4'h8
  } scs_state_e;

  // Prohibited divider codes behave as the slowest legal one
  function automatic logic [2:0] scs_clamp_div(input logic [2:0] div);
    return (div > DIV_SLOWEST) ? DIV_SLOWEST : div;
  endfunction

  // Mask of fxx counts per CPU clock period for a divider code
  function automatic logic [3:0] scs_div_mask(input logic [2:0] div);
    logic [4:0] full;
    full = (5'h01 << scs_clamp_div(div)) - 5'h01;
    return full[3:0];
  endfunction

  // Old-clock instructions to wait before the new setting takes over
  function automatic logic [WAIT_W-1:0] scs_switch_wait(input logic old_sub,
                                                        input logic new_sub,
                                                        input logic main_undivided_select,
                                                        input logic [2:0] old_div);
    logic [2:0] e;
    e = scs_clamp_div(old_div) + (main_undivided_select ? 3'h0 : 3'h1);
    if (old_sub) begin
      return WAIT_FROM_SUB;
    end else if (!new_sub) begin
      return WAIT_M2M_BASE >> scs_clamp_div(old_div);
    end
    case (e)
      3'h0: return WAIT_M2S_E0;
      3'h1: return WAIT_M2S_E1;
      3'h2: return WAIT_M2S_E2;
      3'h3: return WAIT_M2S_E3;
      3'h4: return WAIT_M2S_E4;
      default: return WAIT_M2S_E5;
    endcase
  endfunction

endpackage

// >>> tb/scs_clock_switch_assertions.sv
// Concurrent checks on the clock switch ports.
// Assumes binding to every scs_clock_switch instance.
`timescale 1ns/100ps
module scs_checker
  import scs_pkg::*;
#(
  parameter int STAB_PERIODS = STAB_OSC_PERIODS
) (
  input wire logic core_clk,
  input wire logic resetn,
  input wire logic [ADDR_W-1:0] reg_addr,
  input wire logic [DATA_W-1:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [DATA_W-1:0] reg_rdata,
  input wire logic stop_req,
  input wire logic halt_req,
  input wire logic main_osc_en,
  input wire logic sub_osc_feedback_off,
  input wire logic cpu_clock_source_status,
  input wire logic cpu_running,
  input wire logic cpu_clk_tick,
  input wire logic instr_tick,
  input wire logic wdt_count_en
);
  // ---------------------------------------------------------------
  // Properties
  // ---------------------------------------------------------------
  default clocking cb @(posedge core_clk);
  endclocking
  default disable iff (!resetn);
  wire logic on_sub = cpu_clock_source_status;
  wire logic ctrl_wr = reg_wr && reg_addr == PROC_CLOCK_CTRL_ADDR;
  wire logic ctrl_rd = reg_rd && reg_addr == PROC_CLOCK_CTRL_ADDR;

  // Reset itself must gate the oscillator, so no disable here
  a_osc_reset: assert property (disable iff (1'h0) !resetn |-> !main_osc_en)
    else $error("main oscillator enabled during reset");
  a_status_read: assert property (ctrl_rd |=> reg_rdata[SOURCE_STATUS_BIT] == $past(on_sub))
    else $error("status bit read back wrong");
  a_feedback_wr: assert property (ctrl_wr
    |=> sub_osc_feedback_off == $past(reg_wdata[FEEDBACK_OFF_BIT]))
    else $error("feedback control not taken from write");
  a_stop_main: assert property (stop_req && cpu_running && !on_sub && !halt_req
    |=> !main_osc_en && !cpu_running)
    else $error("stop on main clock not honoured");
  a_stop_sub: assert property (stop_req && cpu_running && on_sub && !halt_req |=> cpu_running)
    else $error("stop accepted on sub clock");
  a_wdt_sub: assert property (on_sub |-> !wdt_count_en)
    else $error("watchdog counts on sub clock");
  a_osc_main: assert property (cpu_running && !on_sub |-> main_osc_en)
    else $error("oscillator stopped while running on main");
  a_instr_pair: assert property (instr_tick |-> cpu_clk_tick)
    else $error("instruction edge off a cpu clock edge");
  a_switch_edge: assert property ($changed(on_sub) |-> $past(instr_tick))
    else $error("source changed off an instruction boundary");

  c_to_sub: cover property ($rose(on_sub));
  c_to_main: cover property ($fell(on_sub));
  c_stop: cover property (stop_req && cpu_running && !on_sub);
endmodule

bind scs_clock_switch scs_checker #(.STAB_PERIODS(STAB_PERIODS)) chk_u (
  .core_clk, .resetn, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata,
  .stop_req, .halt_req, .main_osc_en, .sub_osc_feedback_off,
  .cpu_clock_source_status, .cpu_running, .cpu_clk_tick, .instr_tick, .wdt_count_en
);

// >>> tb/system_clock_switch_control_test.sv
// Self-checking bench: reset test, main rate table, then switch, standby and register tests.
// Assumes the checker is bound; oscillator pins are modelled here.
`timescale 1ns/100ps
`define CHK(nm, ex, got) begin n_compared++; if ((got) !== (ex)) begin bad_count++; \
  $display("MISMATCH %s expected %0h seen %0h", nm, ex, got); end end
module system_clock_switch_control_test
  import scs_pkg::*;
;
  localparam int FX_CYC = 8;
  localparam int SUB_CYC = 32;
  logic core_clk = 1'h0;
  logic resetn = 1'h0;
  logic [ADDR_W-1:0] reg_addr = 8'h00;
  logic [DATA_W-1:0] reg_wdata = 8'h00;
  logic reg_wr = 1'h0;
  logic reg_rd = 1'h0;
  logic main_osc_pin = 1'h0;
  logic sub_osc_pin = 1'h0;
  logic stop_req = 1'h0;
  logic halt_req = 1'h0;
  logic wake_req = 1'h0;
  logic [DATA_W-1:0] reg_rdata;
  logic main_osc_en, sub_osc_feedback_off, cpu_clock_source_status, cpu_running;
  logic cpu_clk_tick, instr_tick, periph_main_tick, periph_sub_tick, wdt_count_en;
  logic [7:0] rows [7] = '{8'h04, 8'h00, 8'h10, 8'h11, 8'h12, 8'h13, 8'h14};
  int bad_count = 0;
  int n_compared = 0;
  int ph = 0;
  int p, n, i;

  scs_clock_switch #(.STAB_PERIODS(8)) dut_u (
    .core_clk, .resetn, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata,
    .main_osc_pin, .sub_osc_pin, .stop_req, .halt_req, .wake_req, .main_osc_en,
    .sub_osc_feedback_off, .cpu_clock_source_status, .cpu_running, .cpu_clk_tick,
    .instr_tick, .periph_main_tick, .periph_sub_tick, .wdt_count_en
  );

  // ---------------------------------------------------------------
  // Clock and oscillators
  // ---------------------------------------------------------------
  always #10 core_clk = ~core_clk;
  // A disabled main oscillator stands still, as the real one would
  always @(posedge core_clk) begin
    ph <= ph + 1;
    if (ph % 4 == 3 && main_osc_en) main_osc_pin <= ~main_osc_pin;
    if (ph % 16 == 15) sub_osc_pin <= ~sub_osc_pin;
  end

  // ---------------------------------------------------------------
  // Tasks
  // ---------------------------------------------------------------
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge core_clk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'h1;
    @(posedge core_clk);
    reg_wr <= 1'h0;
  endtask
  task automatic rd(input logic [7:0] a, input logic [7:0] e, input string nm);
    @(posedge core_clk);
    reg_addr <= a;
    reg_rd <= 1'h1;
    @(posedge core_clk);
    reg_rd <= 1'h0;
    @(negedge core_clk);
    `CHK(nm, e, reg_rdata)
  endtask
  // k: 0 stop, 1 halt, 2 wake
  task automatic pulse(input int k);
    @(posedge core_clk);
    {stop_req, halt_req, wake_req} <= 3'h4 >> k;
    @(posedge core_clk);
    {stop_req, halt_req, wake_req} <= 3'h0;
    @(negedge core_clk);
  endtask
  task automatic tick_gap(output int g);
    do @(negedge core_clk); while (cpu_clk_tick !== 1'h1);
    g = 0;
    do begin @(negedge core_clk); g++; end while (cpu_clk_tick !== 1'h1);
  endtask
  task automatic instr_until(input logic s, output int c);
    c = 0;
    while (cpu_clock_source_status !== s) begin
      @(negedge core_clk);
      if (instr_tick === 1'h1) c++;
    end
  endtask
  task automatic tally_and_finish;
    $display("compared %0d mismatches %0d", n_compared, bad_count);
    if (bad_count == 0 && n_compared > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask

  // ---------------------------------------------------------------
  // Sequence
  // ---------------------------------------------------------------
  initial begin
    repeat (80000) @(posedge core_clk);
    bad_count++;
    $display("watchdog expired");
    tally_and_finish();
  end

  initial begin
    repeat (10) @(posedge core_clk);
    `CHK("osc_en_in_reset", 1'h0, main_osc_en)
    resetn <= 1'h1;
    n = 0;
    // Divider phase runs during the wait, so the run state marks its end, not a tick
    while (cpu_running !== 1'h1) begin @(negedge core_clk); n++; end
    `CHK("stab_wait", 1'h1, n > 56 && n < 80)
    rd(PROC_CLOCK_CTRL_ADDR, 8'h04, "ctrl_reset");
    rd(OSC_MODE_ADDR, 8'h00, "mode_reset");
    $display("reset test done");
    for (i = 0; i < 7; i++) begin
      wr(OSC_MODE_ADDR, {7'h00, rows[i][4]});
      wr(PROC_CLOCK_CTRL_ADDR, {4'h0, rows[i][3:0]});
      repeat (34) tick_gap(p);
      tick_gap(p);
      `CHK("cpu_period", FX_CYC << (rows[i][3:0] + !rows[i][4]), p)
      rd(PROC_CLOCK_CTRL_ADDR, {4'h0, rows[i][3:0]}, "ctrl_div");
      rd(OSC_MODE_ADDR, {7'h00, rows[i][4]}, "mode_sel");
    end
    $display("rate table done");
    wr(PROC_CLOCK_CTRL_ADDR, 8'h94);
    instr_until(1'h1, n);
    `CHK("main_to_sub_wait", 5, n)
    `CHK("osc_kept_until_switch", 1'h1, main_osc_en)
    repeat (2) @(negedge core_clk);
    `CHK("osc_off_on_sub", 1'h0, main_osc_en)
    `CHK("wdt_on_sub", 1'h0, wdt_count_en)
    rd(PROC_CLOCK_CTRL_ADDR, 8'hB4, "ctrl_status");
    wr(PROC_CLOCK_CTRL_ADDR, 8'h90);
    repeat (3) tick_gap(p);
    `CHK("sub_period", 2 * SUB_CYC, p)
    pulse(0);
    `CHK("stop_refused", 1'h1, cpu_running)
    pulse(1);
    `CHK("halt_on_sub", 1'h0, cpu_running)
    n = 0;
    repeat (100) begin @(negedge core_clk); if (periph_sub_tick === 1'h1) n++; end
    `CHK("sub_tick_in_halt", 1'h1, n >= 3)
    pulse(2);
    `CHK("wake_from_halt", 1'h1, cpu_running)
    $display("sub clock test done");
    wr(PROC_CLOCK_CTRL_ADDR, 8'h10);
    // Software owns the restart wait here
    repeat (200) @(negedge core_clk);
    wr(PROC_CLOCK_CTRL_ADDR, 8'h02);
    instr_until(1'h0, n);
    `CHK("sub_to_main_wait", 1, n)
    repeat (3) tick_gap(p);
    `CHK("rate_after_return", FX_CYC << 2, p)
    // Old code 010 keeps the old rate for four instructions
    wr(PROC_CLOCK_CTRL_ADDR, 8'h00);
    n = 0;
    p = -64;
    do begin
      @(negedge core_clk);
      p++;
      if (instr_tick === 1'h1) n++;
      if (cpu_clk_tick === 1'h1 && p != FX_CYC) p = 0;
    end while (cpu_clk_tick !== 1'h1 || p != FX_CYC);
    `CHK("main_to_main_wait", 4, n)
    pulse(0);
    `CHK("stop_on_main", 1'h0, main_osc_en | cpu_running)
    repeat (10) @(negedge core_clk);
    n = 0;
    repeat (100) begin @(negedge core_clk); if (periph_main_tick === 1'h1) n++; end
    `CHK("main_periph_halted", 0, n)
    pulse(2);
    while (cpu_running !== 1'h1) @(negedge core_clk);
    `CHK("osc_after_wake", 1'h1, main_osc_en)
    $display("standby test done");
    wr(PROC_CLOCK_CTRL_ADDR, 8'h6A);
    @(negedge core_clk);
    `CHK("feedback_off", 1'h1, sub_osc_feedback_off)
    wr(8'h10, 8'hFF);
    rd(8'h10, 8'h00, "unmapped");
    rd(PROC_CLOCK_CTRL_ADDR, 8'h42, "ctrl_ro_bits");
    @(posedge core_clk);
    resetn <= 1'h0;
    repeat (3) @(posedge core_clk);
    resetn <= 1'h1;
    rd(PROC_CLOCK_CTRL_ADDR, 8'h04, "ctrl_rereset");
    rd(OSC_MODE_ADDR, 8'h00, "mode_rereset");
    $display("register test done");
    tally_and_finish();
  end
endmodule
